// >>> shared/spi_port_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the serial port
// Assumes: 20 MHz system clock on ref_clk
// Notes: register addresses are the special-function addresses of the port
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

`define SPI_ADDR_CONFIG      8'ha1
`define SPI_ADDR_DIVIDER     8'ha2
`define SPI_ADDR_DATA        8'ha3
`define SPI_ADDR_CONTROL     8'hf8

`define SPI_RESET_CONTROL    8'h06
`define SPI_RESET_CONFIG     8'h07
`define SPI_RESET_DIVIDER    8'h00

`define SPI_BIT_DONE         7
`define SPI_BIT_COLLISION    6
`define SPI_BIT_FAULT        5
`define SPI_BIT_OVERRUN      4
`define SPI_BIT_MODE_HI      3
`define SPI_BIT_MODE_LO      2
`define SPI_BIT_TX_EMPTY     1
`define SPI_BIT_ENABLE       0

`define SPI_BIT_BUSY         7
`define SPI_BIT_MASTER       6
`define SPI_BIT_PHASE        5
`define SPI_BIT_POLARITY     4
`define SPI_BIT_SELECTED     3
`define SPI_BIT_PIN_RAW      2
`define SPI_BIT_SHIFT_EMPTY  1
`define SPI_BIT_RX_EMPTY     0

`define SPI_CLK_HZ           20000000
`define SPI_MASTER_MAX_HZ    12500000
`define SPI_MIN_HALF_CYCLES  ((`SPI_CLK_HZ + 2 * `SPI_MASTER_MAX_HZ - 1) / (2 * `SPI_MASTER_MAX_HZ))
`define SPI_DEGLITCH_CYCLES  2
`define SPI_LAST_HALF        4'hf
`define SPI_LAST_BIT         3'h7

`endif

// >>> shared/spi_port_pkg.sv
// Purpose: types shared by the serial port modules
// Assumes: nothing
// Notes: constants live in the defs header
package spi_port_pkg;
    typedef logic [7:0] byte_type;
    typedef enum logic {master_idle, master_shift} master_state_type;
endpackage : spi_port_pkg

// >>> shared/spi_pin_if.sv
// Purpose: synchronised pin levels handed from the pin stage to the port core
// Assumes: single clock domain
// Notes: select_clean is the de-glitched select level
`timescale 1ns/100ps
interface spi_pin_if;
    logic sck_sync;
    logic mosi_sync;
    logic miso_sync;
    logic select_sync;
    logic select_clean;
    modport source (output sck_sync, mosi_sync, miso_sync, select_sync, select_clean);
    modport sink   (input  sck_sync, mosi_sync, miso_sync, select_sync, select_clean);
endinterface : spi_pin_if

// >>> core/spi_pin_sync.sv
// Purpose: two-flop synchronisers for the serial pins and a select de-glitcher
// Assumes: pins asynchronous to ref_clk
// Notes: adds two cycles of latency on every pin, four on the de-glitched select level
`timescale 1ns/100ps
`include "spi_port_defs.svh"
module spi_pin_sync (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    // raw pins
    input  wire logic sck_in,
    input  wire logic mosi_in,
    input  wire logic miso_in,
    input  wire logic select_line_n_in,
    // synchronised levels
    spi_pin_if.source pins
);
    import spi_port_pkg::*;

    localparam logic [3:0] IDLE_LEVELS = 4'h8;
    logic [3:0] raw;
    logic [3:0] stage_a;
    logic [3:0] stage_b;
    logic [1:0] hold;
    logic       clean;

    assign raw = {select_line_n_in, miso_in, mosi_in, sck_in};

    // the far master's rate limits leave room for this latency
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_sync
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage_a[i] <= IDLE_LEVELS[i];
                    stage_b[i] <= IDLE_LEVELS[i];
                end else if (clk_en) begin
                    stage_a[i] <= raw[i];
                    stage_b[i] <= stage_a[i];
                end
            end
        end
    endgenerate

    // select must differ for several cycles before it is believed
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            clean <= 1'b1;
            hold  <= 2'h0;
        end else if (clk_en) begin
            if (stage_b[3] == clean) begin
                hold <= 2'h0;
            end else if (hold == 2'(`SPI_DEGLITCH_CYCLES - 1)) begin
                clean <= stage_b[3];
                hold  <= 2'h0;
            end else begin
                hold <= hold + 2'h1;
            end
        end
    end

    assign pins.sck_sync     = stage_b[0];
    assign pins.mosi_sync    = stage_b[1];
    assign pins.miso_sync    = stage_b[2];
    assign pins.select_sync  = stage_b[3];
    assign pins.select_clean = clean;
endmodule : spi_pin_sync

// >>> core/spi_port.sv
// Purpose: full-duplex serial port, master or slave, with its four registers
// Assumes: special-function register strobes on ref_clk; pins pass spi_pin_sync
// Notes: all outputs registered, so pins lag internal state by one cycle
`timescale 1ns/100ps
`include "spi_port_defs.svh"
module spi_port (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  clk_en,
    // register port
    input  wire spi_port_pkg::byte_type sfr_addr,
    input  wire spi_port_pkg::byte_type sfr_wdata,
    input  wire logic                  sfr_write,
    input  wire logic                  sfr_read,
    output spi_port_pkg::byte_type     sfr_rdata,
    // interrupt request
    output logic                       irq_request,
    // serial pins
    input  wire logic                  sck_in,
    output logic                       sck_out,
    output logic                       sck_oe,
    input  wire logic                  mosi_in,
    output logic                       mosi_out,
    output logic                       mosi_oe,
    input  wire logic                  miso_in,
    output logic                       miso_out,
    output logic                       miso_oe,
    input  wire logic                  select_line_n_in,
    output logic                       select_line_n_out,
    output logic                       select_line_n_oe
);
    import spi_port_pkg::*;

    function automatic logic hit(input byte_type addr, input byte_type target);
        return addr == target;
    endfunction : hit

    // 1 when this edge is the sampling edge for the given phase
    function automatic logic sample_phase(input logic level, input logic pol, input logic pha);
        return (level ^ pol) ^ pha;
    endfunction : sample_phase

    spi_pin_if pins ();

    spi_pin_sync u_sync (
        .ref_clk          (ref_clk),
        .reset_n          (reset_n),
        .clk_en           (clk_en),
        .sck_in           (sck_in),
        .mosi_in          (mosi_in),
        .miso_in          (miso_in),
        .select_line_n_in (select_line_n_in),
        .pins             (pins.source)
    );

    // flags: [3] done, [2] collision, [1] mode fault, [0] overrun
    logic [3:0]       flags;
    logic [3:0]       flag_set;
    logic [1:0]       select_mode;
    logic             tx_empty;
    logic             port_enable;
    logic             master_enable;
    logic             clock_phase;
    logic             clock_polarity;
    byte_type         divider;
    byte_type         tx_buf;
    byte_type         rx_buf;
    logic             rx_empty;
    byte_type         shifter;
    logic             shifter_full;
    logic             rx_bit;
    logic [3:0]       slave_count;
    logic             sck_prev;
    logic             select_prev;
    master_state_type master_state;
    logic [8:0]       half_cnt;
    logic [8:0]       half_len;
    logic [3:0]       half_idx;

    logic ctl_wr, cfg_wr, div_wr, data_wr, data_rd;
    logic master_run, slave_on, slave_selected, busy;
    logic sck_edge, sample_edge, select_fall;
    logic s_sample, s_shift, s_done, s_idle_load;
    logic m_start, half_end, bit_end, m_done;
    logic fault_set, tx_load;

    assign ctl_wr  = clk_en & sfr_write & hit(sfr_addr, `SPI_ADDR_CONTROL);
    assign cfg_wr  = clk_en & sfr_write & hit(sfr_addr, `SPI_ADDR_CONFIG);
    assign div_wr  = clk_en & sfr_write & hit(sfr_addr, `SPI_ADDR_DIVIDER);
    assign data_wr = clk_en & sfr_write & hit(sfr_addr, `SPI_ADDR_DATA);
    assign data_rd = clk_en & sfr_read  & hit(sfr_addr, `SPI_ADDR_DATA);

    assign master_run = port_enable & master_enable;
    assign slave_on   = port_enable & ~master_enable;
    // 3-wire slave is always selected; 4-wire slave follows the select pin
    assign slave_selected = slave_on & ((select_mode == 2'h0) |
                            ((select_mode == 2'h1) & ~pins.select_clean));
    assign busy = (master_state == master_shift) | (slave_count != 4'h0);

    assign sck_edge    = pins.sck_sync != sck_prev;
    assign sample_edge = sck_edge & sample_phase(pins.sck_sync, clock_polarity, clock_phase);
    assign select_fall = select_prev & ~pins.select_clean;

    // slave samples on the mid-bit edge
    assign s_sample    = slave_selected & sample_edge;
    assign s_shift     = slave_selected & sck_edge & ~sample_edge &
                         (slave_count != 4'h0) & (slave_count != 4'h8);
    assign s_done      = s_sample & (slave_count == 4'h7);
    assign s_idle_load = slave_on & ~shifter_full & ~tx_empty & (slave_count == 4'h0);

    // divider ignored as slave, clamped to the fastest legal half period
    assign half_len = (({1'b0, divider} + 9'h001) < 9'(`SPI_MIN_HALF_CYCLES)) ?
                      9'(`SPI_MIN_HALF_CYCLES) : ({1'b0, divider} + 9'h001);
    assign m_start  = master_run & (master_state == master_idle) & ~tx_empty;
    assign half_end = (master_state == master_shift) & (half_cnt == 9'h000);
    // last cycle of each bit: miso taken one clock before the bit ends
    assign bit_end  = half_end & half_idx[0];
    assign m_done   = bit_end & (half_idx == `SPI_LAST_HALF);

    assign fault_set = master_run & (select_mode == 2'h1) & ~pins.select_clean;
    assign tx_load   = m_start | (s_done & ~tx_empty) | s_idle_load;

    assign flag_set[3] = m_done | s_done;
    assign flag_set[2] = data_wr & ~tx_empty;
    assign flag_set[1] = fault_set;
    assign flag_set[0] = s_done & ~rx_empty;

    // a set in the same cycle as a software clear wins
    genvar f;
    generate
        for (f = 0; f < 4; f++) begin : g_flag
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    flags[f] <= 1'(`SPI_RESET_CONTROL >> (`SPI_BIT_OVERRUN + f));
                end else if (clk_en) begin
                    flags[f] <= flag_set[f] | (ctl_wr ? sfr_wdata[`SPI_BIT_OVERRUN + f] : flags[f]);
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            select_mode    <= 2'(`SPI_RESET_CONTROL >> `SPI_BIT_MODE_LO);
            port_enable    <= 1'(`SPI_RESET_CONTROL >> `SPI_BIT_ENABLE);
            master_enable  <= 1'(`SPI_RESET_CONFIG >> `SPI_BIT_MASTER);
            clock_phase    <= 1'(`SPI_RESET_CONFIG >> `SPI_BIT_PHASE);
            clock_polarity <= 1'(`SPI_RESET_CONFIG >> `SPI_BIT_POLARITY);
            divider        <= `SPI_RESET_DIVIDER;
        end else if (clk_en) begin
            if (ctl_wr) begin
                select_mode <= sfr_wdata[`SPI_BIT_MODE_HI:`SPI_BIT_MODE_LO];
                port_enable <= sfr_wdata[`SPI_BIT_ENABLE];
            end
            // software should disable the port first; changes apply at once
            if (cfg_wr) begin
                master_enable  <= sfr_wdata[`SPI_BIT_MASTER];
                clock_phase    <= sfr_wdata[`SPI_BIT_PHASE];
                clock_polarity <= sfr_wdata[`SPI_BIT_POLARITY];
            end
            if (div_wr) begin
                divider <= sfr_wdata;
            end
            // fault overrides a same-cycle software write
            if (fault_set) begin
                master_enable <= 1'b0;
                port_enable   <= 1'b0;
            end
        end
    end

    // transmit buffer: refused while still full
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_buf   <= 8'h00;
            tx_empty <= 1'(`SPI_RESET_CONTROL >> `SPI_BIT_TX_EMPTY);
        end else if (clk_en) begin
            if (data_wr && tx_empty) begin
                tx_buf   <= sfr_wdata;
                tx_empty <= 1'b0;
            end else if (tx_load) begin
                tx_empty <= 1'b1;
            end
        end
    end

    // shift register, msb out first in both roles
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            shifter      <= 8'h00;
            shifter_full <= 1'b0;
            rx_bit       <= 1'b0;
        end else if (clk_en) begin
            if (s_sample) begin
                rx_bit <= pins.mosi_sync;
            end
            if (!port_enable) begin
                shifter_full <= 1'b0;
            end else if (master_enable) begin
                if (m_start) begin
                    shifter <= tx_buf;
                end else if (bit_end) begin
                    shifter <= {shifter[6:0], pins.miso_sync};
                end
            end else if (s_done) begin
                shifter      <= tx_buf;
                shifter_full <= ~tx_empty;
            end else if (s_idle_load) begin
                shifter      <= tx_buf;
                shifter_full <= 1'b1;
            end else if (slave_selected && sck_edge && (sample_edge || clock_phase || slave_count != 4'h0)) begin
                shifter_full <= 1'b1;                   // trailing edge after last sample moves nothing
                if (s_shift) begin
                    shifter <= {shifter[6:0], rx_bit};
                end
            end
        end
    end

    // slave bit counter; in 3-wire mode only a finished byte or disabling the slave clears it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            slave_count <= 4'h0;
            sck_prev    <= 1'b0;
            select_prev <= 1'b1;
        end else if (clk_en) begin
            sck_prev    <= pins.sck_sync;
            select_prev <= pins.select_clean;
            if (!slave_on || ((select_mode == 2'h1) && select_fall)) begin
                slave_count <= 4'h0;
            end else if (s_done) begin
                slave_count <= 4'h0;
            end else if (s_sample) begin
                slave_count <= slave_count + 4'h1;
            end
        end
    end

    // receive buffer: master always overwrites, slave keeps unread byte
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_buf   <= 8'h00;
            rx_empty <= 1'(`SPI_RESET_CONFIG >> `SPI_BIT_RX_EMPTY);
        end else if (clk_en) begin
            if (m_done) begin
                rx_buf <= {shifter[6:0], pins.miso_sync};
            end else if (s_done && rx_empty) begin
                rx_buf   <= {shifter[6:0], pins.mosi_sync};
                rx_empty <= 1'b0;
            end else if (data_rd) begin
                rx_empty <= 1'b1;
            end
        end
    end

    // master sequencer: 16 half periods per byte
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_state <= master_idle;
            half_cnt     <= 9'h000;
            half_idx     <= 4'h0;
        end else if (clk_en) begin
            unique case (master_state)
                master_idle: begin
                    if (m_start) begin
                        master_state <= master_shift;
                        half_cnt     <= half_len - 9'h001;
                        half_idx     <= 4'h0;
                    end
                end
                master_shift: begin
                    if (!master_run || m_done) begin
                        master_state <= master_idle;
                    end else if (half_end) begin
                        half_cnt <= half_len - 9'h001;
                        half_idx <= half_idx + 4'h1;
                    end else begin
                        half_cnt <= half_cnt - 9'h001;
                    end
                end
            endcase
        end
    end

    // registered pin drive
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_out           <= 1'b0;
            sck_oe            <= 1'b0;
            mosi_out          <= 1'b0;
            mosi_oe           <= 1'b0;
            miso_out          <= 1'b0;
            miso_oe           <= 1'b0;
            select_line_n_out <= 1'b1;
            select_line_n_oe  <= 1'b0;
            irq_request       <= 1'b0;
        end else if (clk_en) begin
            sck_out <= clock_polarity ^
                       ((master_state == master_shift) & (half_idx[0] ^ clock_phase));
            sck_oe            <= master_run;
            mosi_out          <= shifter[7];
            mosi_oe           <= master_run;
            miso_out          <= shifter[7];
            miso_oe           <= slave_selected;
            select_line_n_out <= select_mode[0];
            select_line_n_oe  <= port_enable & select_mode[1];
            irq_request       <= |flags;
        end
    end

    // register readback; unmapped addresses read zero
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (clk_en && sfr_read) begin
            if (hit(sfr_addr, `SPI_ADDR_CONTROL)) begin
                sfr_rdata <= {flags, select_mode, tx_empty, port_enable};
            end else if (hit(sfr_addr, `SPI_ADDR_CONFIG)) begin
                sfr_rdata <= {busy, master_enable, clock_phase, clock_polarity, ~pins.select_clean,
                              pins.select_sync, master_enable | ~shifter_full, master_enable | rx_empty};
            end else if (hit(sfr_addr, `SPI_ADDR_DIVIDER)) begin
                sfr_rdata <= divider;
            end else if (hit(sfr_addr, `SPI_ADDR_DATA)) begin
                sfr_rdata <= rx_buf;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence fault_seen;
        clk_en && fault_set ##1 clk_en;
    endsequence
    sequence collide;
        clk_en && data_wr && !tx_empty;
    endsequence

    a_done_sets: assert property ((clk_en && (m_done || s_done)) |=> flags[3])
        else $error("done flag not set after byte");
    a_collision_keeps: assert property (collide |=> flags[2] && tx_buf == $past(tx_buf))
        else $error("collision write changed buffer or missed flag");
    a_fault_irq: assert property (fault_seen |=> flags[1] && irq_request)
        else $error("mode fault did not flag and request");
    a_fault_disables: assert property ((clk_en && fault_set) |=> !master_enable && !port_enable)
        else $error("mode fault left port enabled");
    a_overrun_keeps: assert property ((clk_en && s_done && !rx_empty) |=> flags[0] && rx_buf == $past(rx_buf))
        else $error("overrun lost old byte or missed flag");
    a_sck_idle_level: assert property ((clk_en && master_state == master_idle) |=> sck_out == $past(clock_polarity))
        else $error("serial clock not at idle level");
    a_half_bound: assert property ((master_state == master_shift) |-> half_cnt < half_len)
        else $error("half period counter out of range");
    a_busy_shown: assert property ((clk_en && sfr_read && hit(sfr_addr, `SPI_ADDR_CONFIG) && busy)
                                   |=> sfr_rdata[`SPI_BIT_BUSY])
        else $error("busy bit not reported");
    a_master_status: assert property ((clk_en && sfr_read && hit(sfr_addr, `SPI_ADDR_CONFIG) && master_enable)
                                      |=> sfr_rdata[1] && sfr_rdata[0])
        else $error("master status bits not forced to one");
    a_tx_write_clears: assert property ((clk_en && data_wr && tx_empty) |=> !tx_empty)
        else $error("transmit empty not cleared by write");
    a_count_reset: assert property ((clk_en && slave_on && select_mode == 2'h1 && select_fall)
                                    |=> slave_count == 4'h0)
        else $error("select fall did not reset bit count");
endmodule : spi_port

// >>> sim/spi_far_slave.sv
// Purpose: far-side serial slave that answers the port while it is master
// Assumes: phase 0, polarity 0, always selected
// Notes: reply byte is fixed so the bench can predict it
`timescale 1ns/100ps
module spi_far_slave (
    // serial pins
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // byte seen on mosi
    output logic [7:0]      rx_byte
);
    logic [7:0] tx_byte = 8'h3c;
    logic [2:0] seen    = 3'h0;
    assign miso = tx_byte[7];
    always @(posedge sck) begin
        rx_byte <= {rx_byte[6:0], mosi};
        seen    <= seen + 3'h1;
    end
    // shift on the trailing edge, so a wrong sample point shows;
    // no shift before a sample, so the pin settling out of reset is no edge
    always @(negedge sck) begin
        if (seen != 3'h0) begin
            tx_byte <= {tx_byte[6:0], ~tx_byte[0]};
        end
    end
endmodule : spi_far_slave

// >>> sim/spi_master_slave_status_control_tb.sv
// Purpose: self-checking bench of the serial port
// Assumes: 20 MHz ref_clk, inputs driven 5 ns after the rising edge
// Notes: slave transfers and overrun are driven by the bench acting as far master
`timescale 1ns/100ps
`include "spi_port_defs.svh"
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin err_count++; $display("Error %s exp %h got %h", n, e, s); end end
module spi_master_slave_status_control_tb;
    import spi_port_pkg::*;
    logic        ref_clk = 0, reset_n = 0, sfr_write = 0, sfr_read = 0, sel_n = 1, ext_sck = 0, ext_mosi = 0;
    byte_type    sfr_addr = 0, sfr_wdata = 0, sfr_rdata, rdat, rx_byte, reply;
    logic        irq_request, sck_out, sck_oe, mosi_out, mosi_oe, miso, sel_out, sel_oe, miso_out, miso_oe;
    int          err_count = 0, checked = 0;
    time         t0;
    // write flag, address, data, expected read-back
    logic [24:0] rows [7] = '{25'h0f80006, 25'h0a10007, 25'h0a20000, 25'h0000000,
                              25'h1a20101, 25'h1005500, 25'h1a14047};
    wire         sck = sck_oe ? sck_out : ext_sck;
    wire         mosi = mosi_oe ? mosi_out : ext_mosi;
    wire         sel_pin = sel_oe ? sel_out : sel_n;
    spi_port i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
        .irq_request(irq_request), .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe),
        .mosi_in(mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out),
        .miso_oe(miso_oe), .select_line_n_in(sel_pin), .select_line_n_out(sel_out), .select_line_n_oe(sel_oe));
    spi_far_slave i_far (.sck(sck), .mosi(mosi), .miso(miso), .rx_byte(rx_byte));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic wr(input byte_type a, input byte_type d);
        @(posedge ref_clk);
        #5;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_write = 1;
        @(posedge ref_clk);
        #5 sfr_write = 0;
    endtask : wr
    task automatic rd(input byte_type a);
        @(posedge ref_clk);
        #5;
        sfr_addr = a;
        sfr_read = 1;
        @(posedge ref_clk);
        #5 sfr_read = 0;
        rdat = sfr_rdata;
    endtask : rd
    // far master, phase 0 polarity 0, 6 clocks a half: under clock/10
    task automatic ext_byte(input byte_type d, output byte_type q);
        for (int b = 7; b >= 0; b--) begin
            ext_mosi = d[b];
            repeat (6) @(posedge ref_clk);
            #5 ext_sck = 1;
            q[b] = miso_out;
            repeat (6) @(posedge ref_clk);
            #5 ext_sck = 0;
        end
    endtask : ext_byte
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        #1000000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        #5 reset_n = 1;
        foreach (rows[i]) begin
            if (rows[i][24])
                wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            `CHK("register", rows[i][7:0], rdat)
        end
        `CHK("sck idle", 1'b0, sck_out)
        wr(`SPI_ADDR_CONTROL, 8'h01);
        wr(`SPI_ADDR_DATA, 8'ha5);
        @(posedge sck_out) t0 = $time;
        @(posedge sck_out) `CHK("sck period", 64'd200, $time - t0)
        rd(`SPI_ADDR_CONFIG);
        `CHK("busy", 1'b1, rdat[7])
        rd(`SPI_ADDR_CONTROL);
        for (int k = 0; k < 60 && !rdat[7]; k++)
            rd(`SPI_ADDR_CONTROL);
        `CHK("done", 8'h83, rdat)
        `CHK("far rx", 8'ha5, rx_byte)
        `CHK("irq done", 1'b1, irq_request)
        rd(`SPI_ADDR_DATA);
        `CHK("rx data", 8'h3c, rdat)
        wr(`SPI_ADDR_CONTROL, 8'h05);
        sel_n = 0;
        repeat (8) @(posedge ref_clk);
        rd(`SPI_ADDR_CONTROL);
        `CHK("fault", 8'h26, rdat)
        rd(`SPI_ADDR_CONFIG);
        `CHK("cfg fault", 8'h0b, rdat)
        `CHK("irq fault", 1'b1, irq_request)
        sel_n = 1;
        wr(`SPI_ADDR_CONTROL, 8'h05);
        rd(`SPI_ADDR_CONTROL);
        `CHK("irq clear", 1'b0, irq_request)
        // slave not selected: first byte drops into the shifter, second waits
        wr(`SPI_ADDR_DATA, 8'h11);
        wr(`SPI_ADDR_DATA, 8'h22);
        wr(`SPI_ADDR_DATA, 8'h33);
        rd(`SPI_ADDR_CONTROL);
        `CHK("collision", 8'h45, rdat)
        sel_n = 0;
        ext_byte(8'h96, reply);
        `CHK("slave tx 1", 8'h11, reply)
        `CHK("miso oe", 1'b1, miso_oe)
        ext_byte(8'h5a, reply);
        `CHK("slave tx 2", 8'h22, reply)
        rd(`SPI_ADDR_CONTROL);
        `CHK("overrun", 8'hd7, rdat)
        rd(`SPI_ADDR_CONFIG);
        `CHK("slave status", 8'h0a, rdat)
        rd(`SPI_ADDR_DATA);
        `CHK("slave rx kept", 8'h96, rdat)
        rd(`SPI_ADDR_CONFIG);
        `CHK("rx read", 8'h0b, rdat)
        wr(`SPI_ADDR_CONTROL, 8'h0d);
        rd(`SPI_ADDR_CONTROL);
        `CHK("select high", 10'h30f, {sel_oe, sel_out, rdat})
        wr(`SPI_ADDR_CONTROL, 8'h09);
        rd(`SPI_ADDR_CONTROL);
        `CHK("select low", 10'h20b, {sel_oe, sel_out, rdat})
        wr(`SPI_ADDR_CONFIG, 8'h70);
        rd(`SPI_ADDR_CONFIG);
        `CHK("phase pol", 9'h17b, {sck_out, rdat})
        print_verdict();
    end
endmodule : spi_master_slave_status_control_tb
